// ===== verilog/ifl_pkg.sv
// Constants and types for the I2C indirect firmware loader.
// Assumes an 8-bit I2C sub-address map and a 24-bit internal bus.
`default_nettype none
package ifl_pkg;
   // I2C sub-addresses
   localparam logic [7:0]  SUB_DATA_FIXED = 8'he0;
   localparam logic [7:0]  SUB_DATA_INC   = 8'he1;
   localparam logic [7:0]  SUB_ADDR_LO    = 8'he8;
   localparam logic [7:0]  SUB_ADDR_MID   = 8'he9;
   localparam logic [7:0]  SUB_ADDR_HI    = 8'hea;
   localparam logic [7:0]  SUB_BCAST      = 8'hfe;
   // Device addresses, 7-bit form of write bytes b8 and ba
   localparam logic [6:0]  DEV_ADDR_DEF   = 7'h5c;
   localparam logic [6:0]  DEV_ADDR_ALT   = 7'h5d;
   // Internal processor bus map
   localparam logic [23:0] PCTL_ADDR      = 24'hb00060;
   localparam logic [23:0] PRAM_BASE      = 24'h400000;
   localparam logic [23:0] PRAM_BYTES_DEF = 24'h010000;
   localparam int          PCTL_RST_BIT   = 0;
   localparam int          PCTL_RAM_BIT   = 1;
   // Broadcast
   localparam logic [7:0]  BCAST_ALL      = 8'h0f;
   localparam logic [3:0]  CORES_ALL      = 4'hf;
   localparam logic [3:0]  CORES_ONE      = 4'h1;
   // Reset values
   localparam logic [23:0] ADDR_RST       = 24'h000000;
   localparam logic [7:0]  BCAST_RST      = 8'h00;
   localparam logic [7:0]  SUB_RST        = 8'h00;
   localparam logic [7:0]  PCTL_RST       = 8'h00;
   // Bits in one I2C byte
   localparam logic [3:0]  BYTE_BITS      = 4'h8;

   typedef enum logic [2:0]
   {
      S_IDLE  = 3'h0,
      S_ADDR  = 3'h1,
      S_ACK_A = 3'h3,
      S_SUB   = 3'h2,
      S_ACK_W = 3'h6,
      S_WDATA = 3'h7,
      S_RDATA = 3'h5,
      S_RACK  = 3'h4
   } ifl_state_t;
endpackage
`default_nettype wire

// ===== verilog/ifl_loader.sv
// I2C slave giving indirect access to the internal processor bus.
// Assumes scl/sda pins oversampled by clock; bus side runs on bus_clk.
//
// Functional notes
// - Address bytes e8, e9, ea: low, mid, high
// - Sub-address e0 accesses data, address unchanged
// - Sub-address e1 accesses data, then address advances
// - Control bit 0 set holds processor reset
// - Program RAM starts at 0x400000
// - Device address b8, or ba by strap
// - Writing 0x0f to fe broadcasts to cores
// - Control write 0x03 sets RAM-loaded, keeps reset
// - RAM-loaded makes processor fetch from RAM
// - Control write 0x02 releases reset, keeps flag
// - Slave acknowledges address and written bytes
`timescale 1ns/1ns
`default_nettype none
module ifl_loader
   import ifl_pkg::*;
#(
   parameter logic [23:0] PRAM_BYTES = PRAM_BYTES_DEF
)
(
   // System clock domain
   input  wire logic        clock,
   input  wire logic        resetn,
   // Internal bus clock domain
   input  wire logic        bus_clk,
   input  wire logic        bus_resetn,
   // I2C pins and address strap
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output var  logic        sda_o_q,
   output var  logic        sda_oe_q,
   input  wire logic        address_select_pin,
   // Internal processor bus
   output var  logic        bus_wr_q,
   output var  logic        bus_rd_q,
   output var  logic [23:0] bus_addr_q,
   output var  logic [7:0]  bus_wdata_q,
   output var  logic [3:0]  bus_core_sel_q,
   output var  logic        bus_pram_q,
   input  wire logic [7:0]  bus_rdata,
   // Processor control
   output var  logic        cpu_reset_q,
   output var  logic        cpu_ram_loaded_q,
   output var  logic        cpu_fetch_ram_q
);

   function automatic logic is_data(input logic [7:0] s);
      is_data = (s == SUB_DATA_FIXED) || (s == SUB_DATA_INC);
   endfunction

   function automatic logic in_pram(input logic [23:0] a);
      in_pram = (a >= PRAM_BASE) && ((a - PRAM_BASE) < PRAM_BYTES);
   endfunction

   function automatic logic [7:0] local_rd(input logic [7:0]  s,
                                           input logic [23:0] a,
                                           input logic [7:0]  b);
      case (s)
         SUB_ADDR_LO:  local_rd = a[7:0];
         SUB_ADDR_MID: local_rd = a[15:8];
         SUB_ADDR_HI:  local_rd = a[23:16];
         SUB_BCAST:    local_rd = b;
         default:      local_rd = 8'h00;
      endcase
   endfunction

   // System domain state
   logic        scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
   logic        sel_m, sel_s, dev_sel_q;
   ifl_state_t  st_q;
   logic [3:0]  bit_q;
   logic [7:0]  sh_q, sub_q, bcast_q, rd_q;
   logic        rw_q, master_acknowledge_q;
   logic [23:0] addr_q;
   logic        req_tgl_q, cmd_we_q;
   logic [23:0] cmd_addr_q;
   logic [7:0]  cmd_data_q;
   logic [3:0]  cmd_cores_q;
   logic        ack_m, ack_s, ack_p;
   // Bus domain state
   logic        req_m, req_s, req_p, ack_tgl_q;
   logic [7:0]  rdb_q;

   // Pin decode; only second and third synchroniser stages are read
   wire start_w = scl_s & scl_p & sda_p & ~sda_s;
   wire stop_w  = scl_s & scl_p & ~sda_p & sda_s;
   wire rise_w  = scl_s & ~scl_p;
   wire fall_w  = ~scl_s & scl_p;
   wire in_byte = (st_q == S_ADDR) || (st_q == S_SUB) || (st_q == S_WDATA);
   wire byte_done = fall_w & (bit_q == BYTE_BITS) & in_byte;
   wire [6:0] dev_addr = dev_sel_q ? DEV_ADDR_ALT : DEV_ADDR_DEF;
   wire adr_match = (sh_q[7:1] == dev_addr);
   wire adr_done  = byte_done & (st_q == S_ADDR);
   wire sub_done  = byte_done & (st_q == S_SUB);
   wire wr_byte   = byte_done & (st_q == S_WDATA);
   wire rd_issue  = (adr_done & adr_match & sh_q[0]) |
                    (rise_w & (st_q == S_RACK) & ~sda_s);
   wire bus_wr_go = wr_byte & is_data(sub_q);
   wire bus_rd_go = rd_issue & is_data(sub_q);
   wire bus_go    = bus_wr_go | bus_rd_go;
   wire adv       = bus_go & (sub_q == SUB_DATA_INC);
   wire wr_lo     = wr_byte & (sub_q == SUB_ADDR_LO);
   wire wr_mid    = wr_byte & (sub_q == SUB_ADDR_MID);
   wire wr_hi     = wr_byte & (sub_q == SUB_ADDR_HI);
   wire wr_bc     = wr_byte & (sub_q == SUB_BCAST);
   wire ack_edge  = ack_s ^ ack_p;
   wire [3:0] cores_w = (wr_byte && bcast_q == BCAST_ALL) ?
                        CORES_ALL : CORES_ONE;

   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         {scl_m, scl_s, scl_p} <= 3'h7;
         {sda_m, sda_s, sda_p} <= 3'h7;
         {ack_m, ack_s, ack_p} <= 3'h0;
      end
      else
      begin
         {scl_m, scl_s, scl_p} <= {scl_i, scl_m, scl_s};
         {sda_m, sda_s, sda_p} <= {sda_i, sda_m, sda_s};
         {ack_m, ack_s, ack_p} <= {ack_tgl_q, ack_m, ack_s};
      end
   end

   // Strap chain has no reset so the pin level is caught while held
   always_ff @(posedge clock)
   begin
      sel_m <= address_select_pin;
      sel_s <= sel_m;
      if (!resetn)
         dev_sel_q <= sel_s;
   end

   // Byte engine; acks every matched address and written byte
   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         st_q     <= S_IDLE;
         bit_q    <= 4'h0;
         sh_q     <= 8'h00;
         rw_q     <= 1'b0;
         master_acknowledge_q   <= 1'b0;
         sda_oe_q <= 1'b0;
         sda_o_q  <= 1'b0;
      end
      else if (start_w)
      begin
         st_q     <= S_ADDR;
         bit_q    <= 4'h0;
         sda_oe_q <= 1'b0;
      end
      else if (stop_w)
      begin
         st_q     <= S_IDLE;
         sda_oe_q <= 1'b0;
      end
      else if (rise_w && in_byte)
      begin
         sh_q  <= {sh_q[6:0], sda_s};
         bit_q <= bit_q + 4'h1;
      end
      else if (rise_w && st_q == S_RACK)
         master_acknowledge_q <= ~sda_s;
      else if (fall_w)
      begin
         case (st_q)
            S_ADDR, S_SUB, S_WDATA:
               if (bit_q == BYTE_BITS)
               begin
                  if (st_q == S_ADDR && !adr_match)
                     st_q <= S_IDLE;
                  else
                  begin
                     st_q     <= (st_q == S_ADDR) ? S_ACK_A : S_ACK_W;
                     sda_oe_q <= 1'b1;
                  end
                  if (st_q == S_ADDR)
                     rw_q <= sh_q[0];
               end
            S_ACK_A, S_RACK:
            begin
               bit_q <= 4'h1;
               if ((st_q == S_ACK_A && rw_q) || (st_q == S_RACK && master_acknowledge_q))
               begin
                  st_q     <= S_RDATA;
                  sh_q     <= rd_q;
                  sda_oe_q <= ~rd_q[7];
               end
               else
               begin
                  st_q     <= (st_q == S_ACK_A) ? S_SUB : S_IDLE;
                  bit_q    <= 4'h0;
                  sda_oe_q <= 1'b0;
               end
            end
            S_ACK_W:
            begin
               st_q     <= S_WDATA;
               bit_q    <= 4'h0;
               sda_oe_q <= 1'b0;
            end
            S_RDATA:
               if (bit_q == BYTE_BITS)
               begin
                  st_q     <= S_RACK;
                  sda_oe_q <= 1'b0;
               end
               else
               begin
                  sh_q     <= {sh_q[6:0], 1'b0};
                  sda_oe_q <= ~sh_q[6];
                  bit_q    <= bit_q + 4'h1;
               end
            default:
               st_q <= S_IDLE;
         endcase
      end
   end

   // Sub-address and indirect address registers
   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         sub_q   <= SUB_RST;
         addr_q  <= ADDR_RST;
         bcast_q <= BCAST_RST;
      end
      else
      begin
         if (sub_done)
            sub_q <= sh_q;
         if (wr_lo)
            addr_q[7:0] <= sh_q;
         else if (wr_mid)
            addr_q[15:8] <= sh_q;
         else if (wr_hi)
            addr_q[23:16] <= sh_q;
         else if (adv)
            addr_q <= addr_q + 24'h1;
         if (wr_bc)
            bcast_q <= sh_q;
      end
   end

   // Command launch; fields hold still until the next toggle
   always_ff @(posedge clock)
   begin
      if (!resetn)
      begin
         req_tgl_q   <= 1'b0;
         cmd_we_q    <= 1'b0;
         cmd_addr_q  <= ADDR_RST;
         cmd_data_q  <= 8'h00;
         cmd_cores_q <= CORES_ONE;
         rd_q        <= 8'h00;
      end
      else
      begin
         if (bus_go)
         begin
            req_tgl_q   <= ~req_tgl_q;
            cmd_we_q    <= wr_byte;
            cmd_addr_q  <= addr_q;
            cmd_data_q  <= sh_q;
            cmd_cores_q <= cores_w;
         end
         if (ack_edge)
            rd_q <= rdb_q;
         else if (rd_issue && !is_data(sub_q))
            rd_q <= local_rd(sub_q, addr_q, bcast_q);
      end
   end

   // Bus domain
   wire go_b     = req_s ^ req_p;
   wire pctl_hit = (cmd_addr_q == PCTL_ADDR);
   wire pctl_wr  = go_b & cmd_we_q & pctl_hit;
   wire pctl_rd  = go_b & ~cmd_we_q & pctl_hit;

   always_ff @(posedge bus_clk)
   begin
      if (!bus_resetn)
         {req_m, req_s, req_p} <= 3'h0;
      else
         {req_m, req_s, req_p} <= {req_tgl_q, req_m, req_s};
   end

   always_ff @(posedge bus_clk)
   begin
      if (!bus_resetn)
      begin
         bus_wr_q       <= 1'b0;
         bus_rd_q       <= 1'b0;
         bus_addr_q     <= ADDR_RST;
         bus_wdata_q    <= 8'h00;
         bus_core_sel_q <= CORES_ONE;
         bus_pram_q     <= 1'b0;
      end
      else
      begin
         bus_wr_q <= go_b & cmd_we_q & ~pctl_hit;
         bus_rd_q <= go_b & ~cmd_we_q & ~pctl_hit;
         if (go_b)
         begin
            bus_addr_q     <= cmd_addr_q;
            bus_wdata_q    <= cmd_data_q;
            bus_core_sel_q <= cmd_cores_q;
            bus_pram_q     <= in_pram(cmd_addr_q);
         end
      end
   end

   // Processor control byte; a full write sets both bits
   always_ff @(posedge bus_clk)
   begin
      if (!bus_resetn)
      begin
         cpu_reset_q      <= PCTL_RST[PCTL_RST_BIT];
         cpu_ram_loaded_q <= PCTL_RST[PCTL_RAM_BIT];
         cpu_fetch_ram_q  <= 1'b0;
         ack_tgl_q        <= 1'b0;
         rdb_q            <= 8'h00;
      end
      else
      begin
         if (pctl_wr)
         begin
            cpu_reset_q      <= cmd_data_q[PCTL_RST_BIT];
            cpu_ram_loaded_q <= cmd_data_q[PCTL_RAM_BIT];
         end
         cpu_fetch_ram_q <= cpu_ram_loaded_q;
         if (pctl_rd)
         begin
            rdb_q     <= {6'h00, cpu_ram_loaded_q, cpu_reset_q};
            ack_tgl_q <= ~ack_tgl_q;
         end
         else if (bus_rd_q)
         begin
            rdb_q     <= bus_rdata;
            ack_tgl_q <= ~ack_tgl_q;
         end
      end
   end

   // Checks
   property p_addr_lo;
      @(posedge clock) disable iff (!resetn)
      wr_lo |=> addr_q[7:0] == $past(sh_q);
   endproperty
   a_addr_lo: assert property (p_addr_lo)
      else $error("low address byte not stored");

   property p_fixed;
      @(posedge clock) disable iff (!resetn)
      bus_go && sub_q == SUB_DATA_FIXED |=> $stable(addr_q);
   endproperty
   a_fixed: assert property (p_fixed)
      else $error("fixed port moved the address");

   property p_inc;
      @(posedge clock) disable iff (!resetn)
      bus_wr_go && sub_q == SUB_DATA_INC
         |=> addr_q == $past(addr_q) + 24'h1 && cmd_addr_q == $past(addr_q);
   endproperty
   a_inc: assert property (p_inc)
      else $error("auto-increment port did not advance");

   property p_nomatch;
      @(posedge clock) disable iff (!resetn)
      adr_done && !adr_match && !start_w |=> st_q == S_IDLE && !sda_oe_q;
   endproperty
   a_nomatch: assert property (p_nomatch)
      else $error("foreign address acknowledged");

   property p_ack;
      @(posedge clock) disable iff (!resetn)
      (adr_done && adr_match) || wr_byte ##1 !start_w && !stop_w
         |-> sda_oe_q;
   endproperty
   a_ack: assert property (p_ack)
      else $error("received byte not acknowledged");

   property p_bcast;
      @(posedge clock) disable iff (!resetn)
      bus_wr_go && bcast_q == BCAST_ALL |=> cmd_cores_q == CORES_ALL;
   endproperty
   a_bcast: assert property (p_bcast)
      else $error("broadcast not applied");

   property p_pctl;
      @(posedge bus_clk) disable iff (!bus_resetn)
      pctl_wr |=> cpu_reset_q == $past(cmd_data_q[0]) &&
                  cpu_ram_loaded_q == $past(cmd_data_q[1]);
   endproperty
   a_pctl: assert property (p_pctl)
      else $error("control byte not applied");

   property p_release;
      @(posedge bus_clk) disable iff (!bus_resetn)
      pctl_wr && cmd_data_q == 8'h02 |=> !cpu_reset_q ##1 cpu_fetch_ram_q;
   endproperty
   a_release: assert property (p_release)
      else $error("release did not boot from RAM");

   property p_pram;
      @(posedge bus_clk) disable iff (!bus_resetn)
      go_b && cmd_addr_q == PRAM_BASE |=> bus_pram_q;
   endproperty
   a_pram: assert property (p_pram)
      else $error("program RAM base not decoded");

endmodule
`default_nettype wire

// ===== verification/ifl_i2c_host.sv
// I2C host model driving the loader's serial pins.
// Assumes a pull-up on sda only; scl is driven high and low by the model, and the bench resolves sda.
`timescale 1ns/1ns
`default_nettype none
module ifl_i2c_host
(
   // Timing reference
   input  wire logic clock,
   // Serial pins
   output var  logic scl,
   output var  logic sda_low,
   input  wire logic sda
);
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask

   // SDA moves only well inside SCL low, so no false start or stop
   task automatic put(input logic b, output logic s);
      cyc(5);
      sda_low = !b;
      cyc(25);
      scl = 1'b1;
      cyc(10);
      s = sda;
      cyc(10);
      scl = 1'b0;
   endtask

   // Serves as repeated start too
   task automatic start();
      cyc(5);
      sda_low = 1'b0;
      scl = 1'b1;
      cyc(20);
      sda_low = 1'b1;
      cyc(20);
      scl = 1'b0;
   endtask

   task automatic stop();
      cyc(5);
      sda_low = 1'b1;
      cyc(25);
      scl = 1'b1;
      cyc(20);
      sda_low = 1'b0;
      cyc(20);
   endtask

   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         put(d[i], s);
      put(1'b1, s);
      ack = !s;
   endtask

   task automatic rbyte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 0; i < 8; i++)
      begin
         put(1'b1, s);
         d = {d[6:0], s};
      end
      put(last, s);
   endtask
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the I2C indirect firmware loader.
// Assumes the host model ifl_i2c_host and a bench memory model.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import ifl_pkg::*;
   logic        clock;
   logic        resetn;
   logic        bus_clk;
   logic        bus_resetn;
   logic        scl;
   logic        host_low;
   logic        sda_o_q;
   logic        sda_oe_q;
   logic        strap;
   wire  logic  sda;
   logic        bus_wr_q;
   logic        bus_rd_q;
   logic [23:0] bus_addr_q;
   logic [7:0]  bus_wdata_q;
   logic [3:0]  bus_core_sel_q;
   logic        bus_pram_q;
   logic [7:0]  bus_rdata = 8'h00;
   logic        cpu_reset_q;
   logic        cpu_ram_loaded_q;
   logic        cpu_fetch_ram_q;
   int          error_cnt = 0;
   int          checked = 0;
   int          cycles = 0;
   logic [31:0] rnd = 32'h00002262;
   logic [6:0]  dev = DEV_ADDR_DEF;
   logic [23:0] addr = 24'h000000;
   logic [7:0]  bcast = 8'h00;
   logic [7:0]  pctl = 8'h00;
   logic [7:0]  mem [int];
   logic [36:0] expq [$];

   // Open drain: the loader pulls low only while enabled with a low value
   assign sda = !(host_low | (sda_oe_q & !sda_o_q));

   initial
   begin
      clock = 1'b0;
      forever #25 clock = !clock;
   end
   initial
   begin
      bus_clk = 1'b0;
      #7;
      forever #16 bus_clk = !bus_clk;
   end

   ifl_loader i_dut (.clock, .resetn, .bus_clk, .bus_resetn, .scl_i(scl),
      .sda_i(sda), .sda_o_q, .sda_oe_q, .address_select_pin(strap),
      .bus_wr_q, .bus_rd_q, .bus_addr_q, .bus_wdata_q, .bus_core_sel_q,
      .bus_pram_q, .bus_rdata, .cpu_reset_q, .cpu_ram_loaded_q,
      .cpu_fetch_ram_q);
   ifl_i2c_host i_host (.clock, .scl, .sda_low(host_low), .sda);

   task automatic conclude();
      $display("checked=%0d error_cnt=%0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [36:0] seen, input logic [36:0] exp);
      checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   function automatic logic [7:0] xs();
      rnd ^= rnd << 13;
      rnd ^= rnd >> 17;
      rnd ^= rnd << 5;
      return rnd[7:0];
   endfunction

   // Released read data wanders, so a late sample cannot pass by luck
   always @(negedge bus_clk)
      bus_rdata <= bus_rd_q ? mem[int'(bus_addr_q)] : ~bus_rdata;

   always @(posedge bus_clk)
      if (bus_wr_q === 1'b1)
      begin
         if (expq.size() == 0)
            chk(37'h1, 37'h0);
         else
            chk({bus_pram_q, bus_core_sel_q, bus_addr_q, bus_wdata_q},
                expq.pop_front());
      end

   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 70000)
      begin
         error_cnt++;
         conclude();
      end
   end

   // Model queues the bus write before the byte goes out on the wire
   task automatic put_byte(input logic [7:0] sub, input logic [7:0] d);
      logic [3:0] m;
      logic       p;
      m = (bcast == BCAST_ALL) ? CORES_ALL : CORES_ONE;
      p = addr >= PRAM_BASE && addr < PRAM_BASE + PRAM_BYTES_DEF;
      case (sub)
         SUB_ADDR_LO:  addr[7:0] = d;
         SUB_ADDR_MID: addr[15:8] = d;
         SUB_ADDR_HI:  addr[23:16] = d;
         SUB_BCAST:    bcast = d;
         SUB_DATA_FIXED, SUB_DATA_INC:
         begin
            if (addr == PCTL_ADDR)
               pctl = d & 8'h03;
            else
            begin
               mem[int'(addr)] = d;
               expq.push_back({p, m, addr, d});
            end
            if (sub == SUB_DATA_INC)
               addr++;
         end
         default: ;
      endcase
   endtask

   function automatic logic [7:0] peek(input logic [7:0] sub);
      case (sub)
         SUB_ADDR_LO:  return addr[7:0];
         SUB_ADDR_MID: return addr[15:8];
         SUB_ADDR_HI:  return addr[23:16];
         SUB_BCAST:    return bcast;
         SUB_DATA_FIXED, SUB_DATA_INC:
            return (addr == PCTL_ADDR) ? pctl : mem[int'(addr)];
         default:      return 8'h00;
      endcase
   endfunction

   task automatic wr(input logic [7:0] sub, input logic [7:0] q [$]);
      logic ack;
      i_host.start();
      i_host.wbyte({dev, 1'b0}, ack);
      chk(ack, 37'h1);
      i_host.wbyte(sub, ack);
      chk(ack, 37'h1);
      foreach (q[i])
      begin
         put_byte(sub, q[i]);
         i_host.wbyte(q[i], ack);
         chk(ack, 37'h1);
      end
      i_host.stop();
   endtask

   task automatic rd(input logic [7:0] sub, input int n);
      logic       ack;
      logic [7:0] d;
      i_host.start();
      i_host.wbyte({dev, 1'b0}, ack);
      i_host.wbyte(sub, ack);
      i_host.start();
      i_host.wbyte({dev, 1'b1}, ack);
      chk(ack, 37'h1);
      for (int i = 0; i < n; i++)
      begin
         i_host.rbyte(i == n - 1, d);
         chk(d, peek(sub));
         if (sub == SUB_DATA_INC)
            addr++;
      end
      i_host.stop();
   endtask

   task automatic seta(input logic [23:0] a);
      wr(SUB_ADDR_LO, '{a[7:0]});
      wr(SUB_ADDR_MID, '{a[15:8]});
      wr(SUB_ADDR_HI, '{a[23:16]});
   endtask

   task automatic ctl(input logic [7:0] v);
      wr(SUB_DATA_FIXED, '{v});
      i_host.cyc(40);
      chk({cpu_reset_q, cpu_ram_loaded_q}, {pctl[0], pctl[1]});
   endtask

   task automatic nak(input logic [6:0] a);
      logic ack;
      i_host.start();
      i_host.wbyte({a, 1'b0}, ack);
      chk(ack, 37'h0);
      i_host.stop();
   endtask

   initial
   begin
      logic [7:0] img [$];
      resetn = 1'b0;
      bus_resetn = 1'b0;
      strap = 1'b0;
      repeat (3) @(negedge clock);
      resetn = 1'b1;
      bus_resetn = 1'b1;
      i_host.cyc(8);
      chk({sda_o_q, sda_oe_q, cpu_reset_q, cpu_ram_loaded_q,
           cpu_fetch_ram_q, bus_core_sel_q}, 37'h01);
      nak(DEV_ADDR_ALT);
      // Load order: reset, broadcast, point, stream, flag, release
      seta(PCTL_ADDR);
      ctl(8'h01);
      rd(SUB_DATA_FIXED, 2);
      wr(SUB_BCAST, '{BCAST_ALL});
      rd(SUB_BCAST, 1);
      seta(PRAM_BASE);
      for (int i = 0; i < 8; i++)
         img.push_back(xs());
      wr(SUB_DATA_INC, img);
      seta(PCTL_ADDR);
      ctl(8'h03);
      ctl(8'h02);
      chk(cpu_fetch_ram_q, 37'h1);
      wr(SUB_BCAST, '{8'h00});
      seta(PRAM_BASE + 24'h000003);
      wr(SUB_DATA_FIXED, '{xs(), xs()});
      seta(PRAM_BASE);
      rd(SUB_DATA_INC, 4);
      rd(SUB_ADDR_LO, 1);
      // Second reset picks the other address; both domains go down
      // together so the request and answer toggles stay paired
      strap = 1'b1;
      resetn = 1'b0;
      bus_resetn = 1'b0;
      addr = ADDR_RST;
      bcast = BCAST_RST;
      pctl = PCTL_RST;
      repeat (4) @(negedge clock);
      resetn = 1'b1;
      bus_resetn = 1'b1;
      i_host.cyc(8);
      dev = DEV_ADDR_ALT;
      nak(DEV_ADDR_DEF);
      // Address is back at its reset value, outside program RAM
      wr(SUB_DATA_FIXED, '{xs()});
      wr(SUB_ADDR_LO, '{xs()});
      rd(SUB_ADDR_LO, 1);
      i_host.cyc(100);
      chk(37'(expq.size()), 37'h0);
      conclude();
   end
endmodule
`default_nettype wire
